// ==== rtl/hdjh_regs.svh ====
// Constants for the heater diagnosis job handler
`ifndef HDJH_REGS_SVH
`define HDJH_REGS_SVH
`define HDJH_JOB_CHAN 8'h0a
`define HDJH_JOB_FIELD 8'h0b
`define HDJH_JOB_GENDIAG 8'h14
`define HDJH_MODE_NONE 8'h00
`define HDJH_MODE_STD 8'h01
`define HDJH_MODE_EXT 8'h02
`define HDJH_FSET_OFF 8'h00
`define HDJH_FSET_ON 8'h01
`define HDJH_RESP_LEN 5'h14
`define HDJH_INIT_OLD_BIT 0
`define HDJH_INIT_NOID_BIT 1
`define HDJH_INIT_FREQ_BIT 2
`define HDJH_MOD_OK 8'h00
`define HDJH_MOD_WARN 8'h01
`define HDJH_MOD_TRIP 8'h02
`define HDJH_MOD_24V 8'h03
`define HDJH_NUM_CHAN 256
`define HDJH_NUM_FIELD 128
`define HDJH_NUM_MOD 16
`endif

// ==== rtl/hdjh_pkg.sv ====
// Types for the heater diagnosis job handler
package hdjh_pkg;
  typedef enum logic [3:0] {
    HDJH_IDLE = 4'b0000,
    HDJH_CH_HI = 4'b0001,
    HDJH_CH_LO = 4'b0010,
    HDJH_CH_MODE = 4'b0011,
    HDJH_CH_P0 = 4'b0100,
    HDJH_CH_P1 = 4'b0101,
    HDJH_CH_D0 = 4'b0110,
    HDJH_CH_D1 = 4'b0111,
    HDJH_FL_NUM = 4'b1000,
    HDJH_FL_SET = 4'b1001,
    HDJH_RESP = 4'b1010,
    HDJH_SKIP = 4'b1011
  } hdjh_state_e;
  typedef logic [1:0] hdjh_mode_t;
endpackage

// ==== rtl/hdjh_chan_mem.sv ====
// Per-channel diagnosis configuration memory with registered read port
`timescale 1ns/1ps
`default_nettype none
module hdjh_chan_mem (
  input wire logic SYS_CLK, // Clock
  input wire logic RST_B, // Async reset, active low
  input wire logic WR_EN, // Write strobe
  input wire logic [7:0] WR_ADDR, // Write channel
  input wire logic [33:0] WR_DATA, // Mode, power, deviation
  input wire logic [7:0] RD_ADDR, // Read channel
  output logic [33:0] RD_DATA // Registered read data
);
  logic [33:0] mem_reg [0:255];
  logic [255:0] valid_reg;
  logic [33:0] rd_reg;
  // Write array, track written entries, register read
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      valid_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (WR_EN) begin
        valid_reg[WR_ADDR] <= 1'b1;
      end
      // Unwritten channels read as standard mode
      rd_reg <= valid_reg[RD_ADDR] ? mem_reg[RD_ADDR] : {2'h1, 32'h0};
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (WR_EN) begin
      mem_reg[WR_ADDR] <= WR_DATA;
    end
  end
  assign RD_DATA = rd_reg;
endmodule
`default_nettype wire

// ==== rtl/hdjh_top.sv ====
// Heater diagnosis job handler: config jobs and general fault report
`timescale 1ns/1ps
`default_nettype none
`include "hdjh_regs.svh"
module hdjh_top
  import hdjh_pkg::*;
(
  input wire logic SYS_CLK, // 250 MHz clock
  input wire logic RST_B, // Async reset, active low
  input wire logic JOB_VALID, // Job byte valid
  input wire logic JOB_FIRST, // Byte is the job code
  input wire logic JOB_LAST, // Last byte of the job
  input wire logic [7:0] JOB_DATA, // Job byte
  output logic JOB_READY, // Handler accepts byte
  output logic RSP_VALID, // Response byte valid
  output logic [7:0] RSP_DATA, // Response byte
  output logic RSP_LAST, // Last response byte
  input wire logic RSP_READY, // Master takes byte
  input wire logic [23:0] PHASE_FAULT, // Phase L1..L3 fault codes
  input wire logic [2:0] INIT_ERR, // Init error flags
  input wire logic [127:0] MOD_FAULT, // Module fault codes, 8 bits each
  input wire logic LINE_SENSOR_PRESENT, // Line measurement unit fitted
  input wire logic [15:0] LINE_MEAS_VOLT, // Measured line voltage
  input wire logic [15:0] LINE_NOM_VOLT, // Nominal line voltage parameter
  output logic [15:0] CALC_VOLT, // Voltage for power calculation
  input wire logic [7:0] QUERY_CHAN, // Channel to query
  input wire logic [6:0] QUERY_FIELD, // Field of queried channel
  output logic QUERY_TEST, // Channel shall be tested
  output logic [1:0] QUERY_MODE, // Channel diagnosis mode
  output logic [15:0] QUERY_POWER, // Expected rated power, W
  output logic [15:0] QUERY_DEV // Permissible deviation, W
);
  hdjh_state_e state_reg, state_next;
  logic [7:0] chan_reg, chan_next;
  logic [1:0] mode_reg, mode_next;
  logic [15:0] pwr_reg, pwr_next;
  logic [15:0] dev_reg, dev_next;
  logic [6:0] fnum_reg, fnum_next;
  logic [4:0] idx_reg, idx_next;
  logic [127:0] fen_reg, fen_next;
  logic [7:0] rsp_reg, rsp_next;
  logic test_reg, test_next;
  logic [1:0] qmode_reg, qmode_next;
  logic [15:0] qpwr_reg, qpwr_next;
  logic [15:0] qdev_reg, qdev_next;
  logic [15:0] volt_reg, volt_next;
  logic wr_en;
  logic commit_reg, commit_next;
  logic [33:0] rd_data;
  logic take;

  // Mode byte legality check
  function automatic logic mode_ok(input logic [7:0] b);
    mode_ok = (b == `HDJH_MODE_NONE) || (b == `HDJH_MODE_STD) || (b == `HDJH_MODE_EXT);
  endfunction

  // Report byte selector; reads only, never clears sources
  function automatic logic [7:0] rsp_byte(input logic [4:0] i, input logic [23:0] ph,
                                          input logic [2:0] ie, input logic [127:0] mf);
    rsp_byte = 8'h00;
    if (i < 5'h03) begin
      rsp_byte = ph[i*8 +: 8];
    end else if (i == 5'h03) begin
      rsp_byte = {5'h00, ie};
    end else if (i < `HDJH_RESP_LEN) begin
      rsp_byte = mf[(i - 5'h04)*8 +: 8];
    end
  endfunction

  hdjh_chan_mem u_mem (
    .SYS_CLK(SYS_CLK),
    .RST_B(RST_B),
    .WR_EN(wr_en),
    .WR_ADDR(chan_reg),
    .WR_DATA({mode_reg, pwr_reg, dev_reg}),
    .RD_ADDR(QUERY_CHAN),
    .RD_DATA(rd_data)
  );

  assign take = JOB_VALID && JOB_READY;
  // Write one cycle after the entry's last byte, once all fields sit in registers
  assign wr_en = commit_reg;
  // Hold off the bus while an extended entry is written; no loop through take
  assign JOB_READY = (state_reg != HDJH_RESP) && !(commit_reg && mode_reg == 2'h2);
  assign RSP_VALID = (state_reg == HDJH_RESP);
  assign RSP_DATA = rsp_reg;
  assign RSP_LAST = RSP_VALID && (idx_reg == `HDJH_RESP_LEN - 5'h01);

  // Job parser and response sequencer
  always_comb begin
    state_next = state_reg;
    chan_next = chan_reg;
    mode_next = mode_reg;
    pwr_next = pwr_reg;
    dev_next = dev_reg;
    fnum_next = fnum_reg;
    idx_next = idx_reg;
    fen_next = fen_reg;
    rsp_next = rsp_reg;
    commit_next = 1'b0;
    if (state_reg == HDJH_RESP) begin
      if (RSP_READY) begin
        if (idx_reg == `HDJH_RESP_LEN - 5'h01) begin
          state_next = HDJH_IDLE;
        end else begin
          idx_next = idx_reg + 5'h01;
          rsp_next = rsp_byte(idx_reg + 5'h01, PHASE_FAULT, INIT_ERR, MOD_FAULT);
        end
      end
    end else if (take && JOB_FIRST) begin
      unique case (JOB_DATA)
        `HDJH_JOB_CHAN: state_next = JOB_LAST ? HDJH_IDLE : HDJH_CH_HI;
        `HDJH_JOB_FIELD: state_next = JOB_LAST ? HDJH_IDLE : HDJH_FL_NUM;
        `HDJH_JOB_GENDIAG: begin
          state_next = HDJH_RESP;
          idx_next = 5'h00;
          rsp_next = rsp_byte(5'h00, PHASE_FAULT, INIT_ERR, MOD_FAULT);
        end
        default: state_next = JOB_LAST ? HDJH_IDLE : HDJH_SKIP;
      endcase
    end else if (take) begin
      unique case (state_reg)
        HDJH_CH_HI: state_next = HDJH_CH_LO; // High byte ignored, 256 channels
        HDJH_CH_LO: begin
          chan_next = JOB_DATA;
          state_next = HDJH_CH_MODE;
        end
        HDJH_CH_MODE: begin
          pwr_next = 16'h0000;
          dev_next = 16'h0000;
          mode_next = JOB_DATA[1:0];
          if (JOB_DATA == `HDJH_MODE_EXT) begin
            state_next = HDJH_CH_P0;
          end else if (mode_ok(JOB_DATA)) begin
            commit_next = 1'b1;
            state_next = HDJH_CH_HI;
          end else begin
            state_next = HDJH_CH_HI;
          end
        end
        HDJH_CH_P0: begin
          pwr_next = {JOB_DATA, 8'h00};
          state_next = HDJH_CH_P1;
        end
        HDJH_CH_P1: begin
          pwr_next = {pwr_reg[15:8], JOB_DATA};
          state_next = HDJH_CH_D0;
        end
        HDJH_CH_D0: begin
          dev_next = {JOB_DATA, 8'h00};
          state_next = HDJH_CH_D1;
        end
        HDJH_CH_D1: begin
          dev_next = {dev_reg[15:8], JOB_DATA};
          commit_next = 1'b1;
          state_next = HDJH_CH_HI;
        end
        HDJH_FL_NUM: begin
          fnum_next = JOB_DATA[6:0];
          state_next = HDJH_FL_SET;
        end
        HDJH_FL_SET: begin
          if (fnum_reg != 7'h00 && JOB_DATA[7] == 1'b0 &&
              (JOB_DATA == `HDJH_FSET_OFF || JOB_DATA == `HDJH_FSET_ON)) begin
            fen_next[fnum_reg] = JOB_DATA[0];
          end
          state_next = HDJH_FL_NUM;
        end
        default: state_next = state_reg;
      endcase
      if (JOB_LAST) begin
        state_next = HDJH_IDLE;
      end
    end
  end

  // Query path: test only if channel and field are both enabled
  always_comb begin
    qmode_next = rd_data[33:32];
    qpwr_next = rd_data[31:16];
    qdev_next = rd_data[15:0];
    test_next = (rd_data[33:32] != 2'h0) && fen_reg[QUERY_FIELD] &&
                (QUERY_FIELD != 7'h00);
    volt_next = LINE_SENSOR_PRESENT ? LINE_MEAS_VOLT : LINE_NOM_VOLT;
  end

  // State registers
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= HDJH_IDLE;
      chan_reg <= 8'h00;
      mode_reg <= 2'h0;
      pwr_reg <= 16'h0000;
      dev_reg <= 16'h0000;
      fnum_reg <= 7'h00;
      idx_reg <= 5'h00;
      fen_reg <= '0;
      rsp_reg <= 8'h00;
      test_reg <= 1'b0;
      qmode_reg <= 2'h0;
      qpwr_reg <= 16'h0000;
      qdev_reg <= 16'h0000;
      volt_reg <= 16'h0000;
      commit_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      chan_reg <= chan_next;
      mode_reg <= mode_next;
      pwr_reg <= pwr_next;
      dev_reg <= dev_next;
      fnum_reg <= fnum_next;
      idx_reg <= idx_next;
      fen_reg <= fen_next;
      rsp_reg <= rsp_next;
      test_reg <= test_next;
      qmode_reg <= qmode_next;
      qpwr_reg <= qpwr_next;
      qdev_reg <= qdev_next;
      volt_reg <= volt_next;
      commit_reg <= commit_next;
    end
  end

  assign QUERY_TEST = test_reg;
  assign QUERY_MODE = qmode_reg;
  assign QUERY_POWER = qpwr_reg;
  assign QUERY_DEV = qdev_reg;
  assign CALC_VOLT = volt_reg;
endmodule
`default_nettype wire

// ==== testbench/hdjh_monitor.sv ====
// Port checker for the job handler
`timescale 1ns/1ps
`default_nettype none
`include "hdjh_regs.svh"
module hdjh_monitor (
  input wire logic SYS_CLK, // Clock
  input wire logic RST_B, // Reset
  input wire logic JOB_VALID, // Byte valid
  input wire logic JOB_FIRST, // Code byte
  input wire logic [7:0] JOB_DATA, // Job byte
  input wire logic JOB_READY, // Byte taken
  input wire logic RSP_VALID, // Report valid
  input wire logic [7:0] RSP_DATA, // Report byte
  input wire logic RSP_LAST, // Last byte
  input wire logic RSP_READY, // Master takes
  input wire logic [23:0] PHASE_FAULT, // Phase codes
  input wire logic LINE_SENSOR_PRESENT, // Sensor
  input wire logic [15:0] LINE_MEAS_VOLT, // Measured
  input wire logic [15:0] LINE_NOM_VOLT, // Nominal
  input wire logic [15:0] CALC_VOLT, // Used voltage
  input wire logic [6:0] QUERY_FIELD, // Field
  input wire logic QUERY_TEST, // Test flag
  input wire logic [1:0] QUERY_MODE // Mode
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  // Report job code taken
  sequence s_rpt_req;
    JOB_VALID && JOB_READY && JOB_FIRST && JOB_DATA == `HDJH_JOB_GENDIAG;
  endsequence
  property p_rpt_start; s_rpt_req |=> RSP_VALID && RSP_DATA == PHASE_FAULT[7:0]; endproperty
  a_rpt_start: assert property (p_rpt_start) else $error("report start");
  property p_rsp_hold; RSP_VALID && !RSP_READY |=> RSP_VALID && $stable(RSP_DATA); endproperty
  a_rsp_hold: assert property (p_rsp_hold) else $error("report byte moved");
  property p_rsp_end; RSP_VALID && RSP_LAST && RSP_READY |=> !RSP_VALID; endproperty
  a_rsp_end: assert property (p_rsp_end) else $error("report too long");
  property p_busy; RSP_VALID |-> !JOB_READY; endproperty
  a_busy: assert property (p_busy) else $error("job taken in report");
  property p_volt_meas; LINE_SENSOR_PRESENT |=> CALC_VOLT == $past(LINE_MEAS_VOLT); endproperty
  a_volt_meas: assert property (p_volt_meas) else $error("measured volt");
  property p_volt_nom; !LINE_SENSOR_PRESENT |=> CALC_VOLT == $past(LINE_NOM_VOLT); endproperty
  a_volt_nom: assert property (p_volt_nom) else $error("nominal volt");
  property p_q_mode; QUERY_TEST |-> QUERY_MODE != 2'h0; endproperty
  a_q_mode: assert property (p_q_mode) else $error("test with mode off");
  property p_q_f0; QUERY_FIELD == 7'h00 [*3] |-> !QUERY_TEST; endproperty
  a_q_f0: assert property (p_q_f0) else $error("field zero tested");
endmodule
bind hdjh_top hdjh_monitor mon (.SYS_CLK, .RST_B, .JOB_VALID, .JOB_FIRST, .JOB_DATA,
  .JOB_READY, .RSP_VALID, .RSP_DATA, .RSP_LAST, .RSP_READY, .PHASE_FAULT,
  .LINE_SENSOR_PRESENT, .LINE_MEAS_VOLT, .LINE_NOM_VOLT, .CALC_VOLT, .QUERY_FIELD,
  .QUERY_TEST, .QUERY_MODE);
`default_nettype wire

// ==== testbench/hdjh_master_model.sv ====
// Fieldbus master model: sends jobs, takes report bytes
`timescale 1ns/1ps
`default_nettype none
module hdjh_master_model (
  input wire logic clk, // Clock
  input wire logic ready, // Job byte taken
  output logic valid, // Job byte valid
  output logic first, // Code byte
  output logic last, // Last byte
  output logic [7:0] data, // Job byte
  input wire logic rsp_valid, // Report valid
  input wire logic [7:0] rsp_data, // Report byte
  input wire logic rsp_last, // Last report byte
  output logic rsp_ready // Report byte taken
);
  logic [7:0] b [20];
  logic l [20];
  // Idle at time zero
  initial begin
    {valid, first, last, data, rsp_ready} = '0;
  end
  // One byte held until taken
  task automatic put(input logic [7:0] d, input logic f, input logic e);
    @(negedge clk);
    {valid, first, last, data} <= {1'b1, f, e, d};
    #1;
    while (!ready) @(negedge clk);
    @(posedge clk);
  endtask
  // Whole job, code byte first, line inverted after
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) put(q[i], i == 0, i == q.size() - 1);
    @(negedge clk);
    {valid, first, last} <= 3'h0;
    data <= ~data;
  endtask
  // Twenty report bytes, st idle cycles before each
  task automatic read(input int st);
    int i;
    int c;
    i = 0;
    c = 0;
    while (i < 20) begin
      @(negedge clk);
      if (rsp_valid && c >= st) begin
        b[i] = rsp_data;
        l[i] = rsp_last;
        rsp_ready <= 1'b1;
        i++;
        c = 0;
      end else begin
        rsp_ready <= 1'b0;
        c++;
      end
    end
    @(negedge clk);
    rsp_ready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/hdjh_top_bench.sv ====
// Self-checking bench for the job handler
`timescale 1ns/1ps
`default_nettype none
module hdjh_top_bench;
  logic clk = 0, rst_b = 0, jv, jf, jl, jr, rv, rl, rr, sp = 1, qt;
  logic [7:0] jd, rd, qc = 0;
  logic [23:0] pf = 0;
  logic [2:0] ie = 0;
  logic [127:0] mf = 0;
  logic [15:0] mv = 16'h00e6, nv = 16'h0190, cv, qp, qd;
  logic [6:0] qf = 0;
  logic [1:0] qm;
  int failures = 0, comparisons = 0;
  hdjh_top uut (.SYS_CLK(clk), .RST_B(rst_b), .JOB_VALID(jv), .JOB_FIRST(jf),
    .JOB_LAST(jl), .JOB_DATA(jd), .JOB_READY(jr), .RSP_VALID(rv), .RSP_DATA(rd),
    .RSP_LAST(rl), .RSP_READY(rr), .PHASE_FAULT(pf), .INIT_ERR(ie), .MOD_FAULT(mf),
    .LINE_SENSOR_PRESENT(sp), .LINE_MEAS_VOLT(mv), .LINE_NOM_VOLT(nv), .CALC_VOLT(cv),
    .QUERY_CHAN(qc), .QUERY_FIELD(qf), .QUERY_TEST(qt), .QUERY_MODE(qm),
    .QUERY_POWER(qp), .QUERY_DEV(qd));
  hdjh_master_model m (.clk(clk), .ready(jr), .valid(jv), .first(jf), .last(jl),
    .data(jd), .rsp_valid(rv), .rsp_data(rd), .rsp_last(rl), .rsp_ready(rr));
  // Clock, 4 ns period
  initial forever #2 clk = ~clk;
  task automatic check(string n, logic [34:0] s, logic [34:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Query a channel, outputs settle two cycles later
  task automatic q(logic [7:0] c, logic [6:0] f, logic [34:0] e);
    @(negedge clk);
    qc = c;
    qf = f;
    repeat (3) @(negedge clk);
    check("query", {qt, qm, qp, qd}, e);
  endtask
  // Expected report byte
  function automatic logic [7:0] ex(int i);
    if (i < 3) return pf[8*i+:8];
    if (i == 3) return {5'h00, ie};
    return mf[8*(i-4)+:8];
  endfunction
  task automatic rpt(int st);
    m.send('{8'h14});
    m.read(st);
    for (int i = 0; i < 20; i++) check("report", {m.l[i], m.b[i]}, {i == 19, ex(i)});
    check("length", rv, 1'b0);
  endtask
  task automatic t_config();
    q(8'h07, 7'h03, {1'b0, 2'h1, 32'h0});
    m.send('{8'h0a, 8'h00, 8'h05, 8'h00, 8'h00, 8'h06, 8'h02, 8'h12, 8'h34, 8'h00, 8'h56,
      8'h00, 8'h07, 8'h03});
    m.send('{8'h0b, 8'h03, 8'h01, 8'h04, 8'h01, 8'h00, 8'h01});
    m.send('{8'h0b, 8'h04, 8'h02});
    q(8'h05, 7'h03, {1'b0, 2'h0, 32'h0});
    q(8'h06, 7'h03, {1'b1, 2'h2, 32'h12340056});
    q(8'h07, 7'h04, {1'b1, 2'h1, 32'h0});
    q(8'h07, 7'h00, {1'b0, 2'h1, 32'h0});
    m.send('{8'h0b, 8'h04, 8'h00});
    q(8'h07, 7'h04, {1'b0, 2'h1, 32'h0});
    m.send('{8'h0a, 8'h00, 8'h05, 8'h01, 8'h00, 8'h06, 8'h01});
    q(8'h05, 7'h03, {1'b1, 2'h1, 32'h0});
    q(8'h06, 7'h03, {1'b1, 2'h1, 32'h0});
    $display("config test done");
  endtask
  task automatic t_report();
    rpt(0);
    pf = 24'h030201;
    ie = 3'h5;
    for (int k = 0; k < 16; k++) mf[8*k+:8] = 8'(k % 4);
    rpt(2);
    rpt(0);
    ie = 3'h7;
    rpt(1);
    $display("report test done");
  endtask
  task automatic t_volt();
    repeat (2) @(negedge clk);
    check("meas volt", cv, mv);
    sp = 0;
    repeat (2) @(negedge clk);
    check("nom volt", cv, nv);
    $display("voltage test done");
  endtask
  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) rst_b = 1;
    t_config();
    t_report();
    t_volt();
    wrap_up();
  end
  // Watchdog
  initial begin
    #40000;
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
